// ### pkg/cdgo_pkg.sv
// constants for the per-channel digital gain / offset register bank
// assumes a single 20 MHz clock and a 32-bit AXI4-Lite register bus
package cdgo_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          SAMPLE_W         = 14;
    localparam int          REG_W            = 16;
    localparam int          COEF_W           = 16;
    localparam int          COEF_FRAC        = 14;
    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_ENABLE       = 6'h03;
    localparam logic [5:0]  IDX_CH5_COPY     = 6'h1A;
    localparam logic [5:0]  IDX_CH6_GO       = 6'h1B;
    localparam logic [5:0]  IDX_CH6_COPY     = 6'h1C;
    localparam logic [5:0]  IDX_CH7_GO       = 6'h1D;
    localparam logic [5:0]  IDX_CH7_COPY     = 6'h1E;
    localparam logic [5:0]  IDX_CH8_GO       = 6'h1F;
    localparam logic [5:0]  IDX_STATUS       = 6'h3F;
    // field positions
    localparam int          GAIN_APPLY_BIT   = 12;
    localparam int          OFFSET_APPLY_BIT = 8;
    localparam int          GAIN_MSB         = 15;
    localparam int          GAIN_LSB         = 11;
    localparam int          OFFSET_MSB       = 9;
    localparam int          STAT_MISMATCH_C6 = 0;
    localparam int          STAT_MISMATCH_C7 = 1;
    localparam logic [15:0] REG_RESET        = 16'h0000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    // gain step of 0.2 dB: unsigned Q2.14 factor 10^(N*0.2/20)
    function automatic logic [COEF_W-1:0] gain_coef(input logic [4:0] n);
        logic [COEF_W-1:0] c;
        c = 16'h4000;
        case (n)
            5'h00: c = 16'h4000;  5'h01: c = 16'h417E;  5'h02: c = 16'h4304;
            5'h03: c = 16'h4494;  5'h04: c = 16'h462D;  5'h05: c = 16'h47CF;
            5'h06: c = 16'h497B;  5'h07: c = 16'h4B32;  5'h08: c = 16'h4CF2;
            5'h09: c = 16'h4EBD;  5'h0A: c = 16'h5092;  5'h0B: c = 16'h5273;
            5'h0C: c = 16'h545F;  5'h0D: c = 16'h5655;  5'h0E: c = 16'h5858;
            5'h0F: c = 16'h5A67;  5'h10: c = 16'h5C82;  5'h11: c = 16'h5EAA;
            5'h12: c = 16'h60DE;  5'h13: c = 16'h6320;  5'h14: c = 16'h656F;
            5'h15: c = 16'h67CC;  5'h16: c = 16'h6A37;  5'h17: c = 16'h6CB0;
            5'h18: c = 16'h6F38;  5'h19: c = 16'h71D0;  5'h1A: c = 16'h7476;
            5'h1B: c = 16'h772D;  5'h1C: c = 16'h79F3;  5'h1D: c = 16'h7CCB;
            5'h1E: c = 16'h7FB2;  5'h1F: c = 16'h82AC;
            default: c = 16'h4000;
        endcase
        return c;
    endfunction
endpackage

// ### rtl/cdgo_correct.sv
// one channel of offset-then-gain correction with saturation
// assumes samples arrive every clock from logic on aclk
module cdgo_correct
    import cdgo_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic signed [cdgo_pkg::SAMPLE_W-1:0] sample,
    input  wire logic        [4:0]             gain_code,
    input  wire logic        [9:0]             offset_value,
    input  wire logic                          gain_apply,
    input  wire logic                          offset_apply,
    output logic signed      [cdgo_pkg::SAMPLE_W-1:0] corr
);
    function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = 32'sh00001FFF;
        lo = -32'sh00002000;
        if (v > hi)
            return hi[SAMPLE_W-1:0];
        else if (v < lo)
            return lo[SAMPLE_W-1:0];
        else
            return v[SAMPLE_W-1:0];
    endfunction

    logic signed [31:0] sum;
    logic signed [31:0] prod;

    always_comb
    begin
        sum = 32'(sample);
        if (offset_apply)
            sum = sum + 32'(signed'(offset_value));
        prod = sum;
        if (gain_apply)
            prod = (sum * 32'(signed'({1'b0, gain_coef(gain_code)}))) >>> COEF_FRAC;
    end

    // a single register stage keeps the multiplier off the output pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            corr <= '0;
        else
            corr <= sat(prod);
    end
endmodule

// ### rtl/cdgo_regs.sv
// gain / offset register bank for channels 5 copy to 8, with AXI4-Lite slave
// assumes one AXI4-Lite master on aclk and sample streams on the same clock
// Functional notes
// - the 5-bit gain code in bits 15..11 is applied as that many 0.2 dB steps.
// - the per-channel gain is applied only while the global gain enable bit 12 is one.
// - the 10-bit offset in bits 9..0 is added only while the global offset enable bit 8 is one.
// - the offset field is a two's-complement number.
// - channel 6 sits at 1Bh with copy 1Ch, channel 7 at 1Dh with copy 1Eh, channel 8 at 1Fh.
//
// Added by the designer: the AXI4-Lite slave port.
module cdgo_regs
    import cdgo_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [cdgo_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [cdgo_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [cdgo_pkg::SAMPLE_W-1:0] sample_c6,
    input  wire logic [cdgo_pkg::SAMPLE_W-1:0] sample_c7,
    input  wire logic [cdgo_pkg::SAMPLE_W-1:0] sample_c8,
    output logic [cdgo_pkg::SAMPLE_W-1:0]      corr_c6,
    output logic [cdgo_pkg::SAMPLE_W-1:0]      corr_c7,
    output logic [cdgo_pkg::SAMPLE_W-1:0]      corr_c8
);
    import cdgo_pkg::*;

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [31:0]      data,
                                               input logic [3:0]       strb);
        logic [REG_W-1:0] m;
        m = old;
        if (strb[0])
            m[7:0] = data[7:0];
        if (strb[1])
            m[15:8] = data[15:8];
        return m;
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        return idx == IDX_ENABLE || idx == IDX_STATUS
            || (idx >= IDX_CH5_COPY && idx <= IDX_CH8_GO);
    endfunction

    logic [REG_W-1:0] enable_r;
    logic [REG_W-1:0] ch5_offset_copy_r;
    logic [REG_W-1:0] ch6_gain_offset_r;
    logic [REG_W-1:0] ch6_offset_copy_r;
    logic [REG_W-1:0] ch7_gain_offset_r;
    logic [REG_W-1:0] ch7_offset_copy_r;
    logic [REG_W-1:0] ch8_gain_offset_r;
    logic [1:0]       mismatch_r;
    logic             aw_held_r;
    logic             w_held_r;
    logic [5:0]       wr_idx_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic             wr_fire;
    logic [REG_W-1:0] rd_word;
    logic             global_gain_apply;
    logic             global_offset_apply;

    assign wr_fire             = aw_held_r && w_held_r && !s_axi_bvalid;
    assign global_gain_apply   = enable_r[GAIN_APPLY_BIT];
    assign global_offset_apply = enable_r[OFFSET_APPLY_BIT];

    // write address / data capture, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            wr_idx_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_held_r     <= 1'b1;
                wr_idx_r      <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_held_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
            // no new write is taken until the response is gone
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wr_idx_r) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // register file; unused bits are stored as written and read back
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_r          <= REG_RESET;
            ch5_offset_copy_r <= REG_RESET;
            ch6_gain_offset_r <= REG_RESET;
            ch6_offset_copy_r <= REG_RESET;
            ch7_gain_offset_r <= REG_RESET;
            ch7_offset_copy_r <= REG_RESET;
            ch8_gain_offset_r <= REG_RESET;
        end
        else if (wr_fire)
        begin
            case (wr_idx_r)
                IDX_ENABLE:   enable_r          <= merge(enable_r, wdata_r, wstrb_r);
                IDX_CH5_COPY: ch5_offset_copy_r <= merge(ch5_offset_copy_r, wdata_r, wstrb_r);
                IDX_CH6_GO:   ch6_gain_offset_r <= merge(ch6_gain_offset_r, wdata_r, wstrb_r);
                IDX_CH6_COPY: ch6_offset_copy_r <= merge(ch6_offset_copy_r, wdata_r, wstrb_r);
                IDX_CH7_GO:   ch7_gain_offset_r <= merge(ch7_gain_offset_r, wdata_r, wstrb_r);
                IDX_CH7_COPY: ch7_offset_copy_r <= merge(ch7_offset_copy_r, wdata_r, wstrb_r);
                IDX_CH8_GO:   ch8_gain_offset_r <= merge(ch8_gain_offset_r, wdata_r, wstrb_r);
                default:      enable_r          <= enable_r;
            endcase
        end
    end

    // copies that disagree are flagged; the primary register is what gets applied
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mismatch_r <= 2'h0;
        else
        begin
            mismatch_r[STAT_MISMATCH_C6] <= ch6_gain_offset_r[OFFSET_MSB:0]
                                         != ch6_offset_copy_r[OFFSET_MSB:0];
            mismatch_r[STAT_MISMATCH_C7] <= ch7_gain_offset_r[OFFSET_MSB:0]
                                         != ch7_offset_copy_r[OFFSET_MSB:0];
        end
    end

    always_comb
    begin
        rd_word = REG_RESET;
        case (s_axi_araddr[ADDR_W-1:2])
            IDX_ENABLE:   rd_word = enable_r;
            IDX_CH5_COPY: rd_word = ch5_offset_copy_r;
            IDX_CH6_GO:   rd_word = ch6_gain_offset_r;
            IDX_CH6_COPY: rd_word = ch6_offset_copy_r;
            IDX_CH7_GO:   rd_word = ch7_gain_offset_r;
            IDX_CH7_COPY: rd_word = ch7_offset_copy_r;
            IDX_CH8_GO:   rd_word = ch8_gain_offset_r;
            IDX_STATUS:   rd_word = {14'h0000, mismatch_r};
            default:      rd_word = REG_RESET;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_word};
            s_axi_rresp   <= mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    cdgo_correct u_c6 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .sample       (sample_c6),
        .gain_code    (ch6_gain_offset_r[GAIN_MSB:GAIN_LSB]),
        .offset_value (ch6_gain_offset_r[OFFSET_MSB:0]),
        .gain_apply   (global_gain_apply),
        .offset_apply (global_offset_apply),
        .corr         (corr_c6)
    );

    cdgo_correct u_c7 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .sample       (sample_c7),
        .gain_code    (ch7_gain_offset_r[GAIN_MSB:GAIN_LSB]),
        .offset_value (ch7_gain_offset_r[OFFSET_MSB:0]),
        .gain_apply   (global_gain_apply),
        .offset_apply (global_offset_apply),
        .corr         (corr_c7)
    );

    cdgo_correct u_c8 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .sample       (sample_c8),
        .gain_code    (ch8_gain_offset_r[GAIN_MSB:GAIN_LSB]),
        .offset_value (ch8_gain_offset_r[OFFSET_MSB:0]),
        .gain_apply   (global_gain_apply),
        .offset_apply (global_offset_apply),
        .corr         (corr_c8)
    );

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_bypass;
        !global_gain_apply && !global_offset_apply |=> corr_c6 == $past(sample_c6);
    endproperty
    a_bypass: assert property (p_bypass) else $error("ch6 altered with both enables off");

    property p_offset_only;
        !global_gain_apply && global_offset_apply && sample_c7[13:12] == 2'h0
        |=> $signed(corr_c7) == $signed($past(sample_c7))
                              + $signed($past(ch7_gain_offset_r[OFFSET_MSB:0]));
    endproperty
    a_offset_only: assert property (p_offset_only) else $error("ch7 offset sum wrong");

    property p_offset_sign;
        !global_gain_apply && global_offset_apply && ch6_gain_offset_r[OFFSET_MSB]
        && sample_c6[13:12] == 2'h0 |=> $signed(corr_c6) < $signed($past(sample_c6));
    endproperty
    a_offset_sign: assert property (p_offset_sign) else $error("negative offset raised ch6");

    property p_gain_step;
        global_gain_apply && !global_offset_apply
        && ch8_gain_offset_r[GAIN_MSB:GAIN_LSB] != 5'h00 && sample_c8[13:6] != 8'h00
        && !sample_c8[13] |=> $signed(corr_c8) > $signed($past(sample_c8));
    endproperty
    a_gain_step: assert property (p_gain_step) else $error("nonzero gain did not raise ch8");

    property p_gain_zero;
        global_gain_apply && !global_offset_apply
        && ch6_gain_offset_r[GAIN_MSB:GAIN_LSB] == 5'h00 |=> corr_c6 == $past(sample_c6);
    endproperty
    a_gain_zero: assert property (p_gain_zero) else $error("zero gain code changed ch6");

    property p_map_c7;
        wr_fire && wr_idx_r == IDX_CH7_GO && wstrb_r[1:0] == 2'h3
        |=> ch7_gain_offset_r == $past(wdata_r[15:0]) && s_axi_bresp == RESP_OKAY;
    endproperty
    a_map_c7: assert property (p_map_c7) else $error("write to channel 7 lost");

    property p_read_turn;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_read_turn: assert property (p_read_turn) else $error("read answer late");

    c_write_c6: cover property (wr_fire && wr_idx_r == IDX_CH6_GO);
    c_both_on:  cover property (global_gain_apply && global_offset_apply);
    c_mismatch: cover property (mismatch_r[STAT_MISMATCH_C6]);
    c_bad_addr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// ### tb/cdgo_regs_tb_top.sv
// self-checking bench for the channel gain / offset register bank
// assumes cdgo_regs is the only design module, on one 20 MHz clock
module cdgo_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cdgo_pkg::*;

    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [13:0] smp6    = 14'h0;
    logic [13:0] smp7    = 14'h0;
    logic [13:0] smp8    = 14'h0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [13:0] corr6;
    logic [13:0] corr7;
    logic [13:0] corr8;
    int          errors     = 0;
    int          num_checks = 0;

    always #25 aclk = ~aclk;

    cdgo_regs u_cdgo_regs (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_c6(smp6),
        .sample_c7(smp7), .sample_c8(smp8), .corr_c6(corr6), .corr_c7(corr7),
        .corr_c8(corr8)
    );

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic miss(input string what);
        errors++;
        $display("Error at %0t ns: %s", $time, what);
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            miss($sformatf("read data %h expected %h", got, exp));
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp)
            miss($sformatf("response %h expected %h", got, exp));
    endtask

    task automatic chk_corr(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp)
            miss($sformatf("corrected sample %h expected %h", got, exp));
    endtask

    task automatic guard(input int n);
        if (n > 50)
        begin
            miss("bus answer never came");
            conclude();
        end
    endtask

    // valids drop at their own handshake edge; bready stays up until bvalid is seen
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
            n++;
            guard(n);
        end
        chk_resp(bresp, er);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
            n++;
            guard(n);
        end
        chk_reg(rdata, ed);
        chk_resp(rresp, er);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // offset first, then gain factor 10^(n/100) in Q2.14, then clip to 14 bits
    function automatic logic [13:0] model(input int s, input int off, input int n,
                                          input bit ge, input bit oe);
        longint v;
        longint c;
        v = s + (oe ? off : 0);
        c = ge ? longint'($rtoi(16384.0 * (10.0 ** (n * 0.01)) + 0.5)) : 64'sd16384;
        v = (v * c) >>> 14;
        if (v > 8191)
            v = 8191;
        if (v < -8192)
            v = -8192;
        return v[13:0];
    endfunction

    task automatic t_reset_values();
        logic [5:0] idx [7];
        idx = '{IDX_ENABLE, IDX_CH5_COPY, IDX_CH6_GO, IDX_CH6_COPY, IDX_CH7_GO,
                IDX_CH7_COPY, IDX_CH8_GO};
        foreach (idx[i])
            axi_read({idx[i], 2'b00}, 32'h0, RESP_OKAY);
    endtask

    // every channel register gets its own pattern before any is read, so aliasing shows
    task automatic t_map();
        logic [5:0]  idx [6];
        logic [15:0] pat [6];
        idx = '{IDX_CH5_COPY, IDX_CH6_GO, IDX_CH6_COPY, IDX_CH7_GO, IDX_CH7_COPY, IDX_CH8_GO};
        pat = '{16'h0155, 16'hF9AA, 16'h01AA, 16'h5201, 16'h0201, 16'h8BFF};
        foreach (idx[i])
            axi_write({idx[i], 2'b00}, {16'hFFFF, pat[i]}, 4'hF, RESP_OKAY);
        foreach (idx[i])
            axi_read({idx[i], 2'b00}, {16'h0, pat[i]}, RESP_OKAY);
        axi_write({IDX_CH8_GO, 2'b00}, 32'h0000_7000, 4'h2, RESP_OKAY);
        axi_read({IDX_CH8_GO, 2'b00}, 32'h0000_70FF, RESP_OKAY);
    endtask

    task automatic t_unmapped();
        axi_write(8'h40, 32'h0000_1234, 4'hF, RESP_SLVERR);
        axi_read(8'h40, 32'h0, RESP_SLVERR);
        axi_write(8'h80, 32'h0000_1234, 4'hF, RESP_SLVERR);
        axi_read(8'h80, 32'h0, RESP_SLVERR);
    endtask

    // all four enable combinations over three channels, negative and clipping cases
    task automatic t_datapath();
        smp6 <= 14'(1000);
        smp7 <= 14'(-8000);
        smp8 <= 14'(8000);
        axi_write({IDX_CH6_GO, 2'b00}, {16'h0, 5'd10, 1'b0, 10'h3FD}, 4'hF, RESP_OKAY);
        // between the two writes of a pair the copies legally disagree for a while
        axi_read({IDX_STATUS, 2'b00}, 32'h0000_0001, RESP_OKAY);
        axi_write({IDX_CH6_COPY, 2'b00}, {22'h0, 10'h3FD}, 4'hF, RESP_OKAY);
        axi_write({IDX_CH7_GO, 2'b00}, {16'h0, 5'd31, 1'b0, 10'h005}, 4'hF, RESP_OKAY);
        axi_write({IDX_CH7_COPY, 2'b00}, {22'h0, 10'h005}, 4'hF, RESP_OKAY);
        axi_write({IDX_CH8_GO, 2'b00}, {16'h0, 5'd31, 11'h0}, 4'hF, RESP_OKAY);
        for (int e = 0; e < 4; e++)
        begin
            axi_write({IDX_ENABLE, 2'b00}, {19'h0, e[1], 3'h0, e[0], 8'h00}, 4'hF, RESP_OKAY);
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk_corr(corr6, model(1000, -3, 10, e[1], e[0]));
            chk_corr(corr7, model(-8000, 5, 31, e[1], e[0]));
            chk_corr(corr8, model(8000, 0, 31, e[1], e[0]));
            @(posedge aclk);
        end
    endtask

    task automatic t_latency();
        @(posedge aclk);
        smp6 <= 14'(-1000);
        @(negedge aclk);
        chk_corr(corr6, model(1000, -3, 10, 1'b1, 1'b1));
        @(posedge aclk);
        @(negedge aclk);
        chk_corr(corr6, model(-1000, -3, 10, 1'b1, 1'b1));
        @(posedge aclk);
    endtask

    // offset alone on a small positive ch7 sample, then gain code zero on ch6
    task automatic t_corner();
        smp7 <= 14'(2000);
        axi_write({IDX_ENABLE, 2'b00}, 32'h0000_0100, 4'hF, RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk_corr(corr7, model(2000, 5, 31, 1'b0, 1'b1));
        @(posedge aclk);
        axi_write({IDX_CH6_GO, 2'b00}, {16'h0, 5'd0, 1'b0, 10'h3FD}, 4'hF, RESP_OKAY);
        axi_write({IDX_ENABLE, 2'b00}, 32'h0000_1000, 4'hF, RESP_OKAY);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk_corr(corr6, model(-1000, -3, 0, 1'b1, 1'b0));
        chk_corr(corr8, model(8000, 0, 31, 1'b1, 1'b0));
        @(posedge aclk);
        axi_read({IDX_STATUS, 2'b00}, 32'h0, RESP_OKAY);
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values();
        t_map();
        t_unmapped();
        t_datapath();
        t_latency();
        t_corner();
        conclude();
    end
endmodule
